// *** verilog/dual_pot_serial_control.sv ***
// serial slave control logic for a dual 64-tap potentiometer
//
// Operation
// - sample serial input on clock rise
// - serial output changes only on clock fall
// - deselected: output floats, nv write finishes
// - sequence starts only after select falls
// - internal write launches on select rise
// - write protect low blocks slot writes
// - protect falling while selected aborts write
// - launched write ignores later protect fall
// - paused: output floats, input ignored
// - resume while clock low, continue sequence
// - power-up copies slot 0 into wiper
// - each pot has own 6-bit wiper
// - four 6-bit setting slots per pot
// - respond only when strap address matches
// - clock modes (0,0) and (1,1) only
// - wiper picks one of 64 taps
// - first byte is the instruction
// - exactly one tap per pot connected
`timescale 1ns/1ps
`default_nettype none
`include "dual_pot_map.svh"
module dual_pot_serial_control
  import dual_pot_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYC = (`NV_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // system
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // serial bus
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // control pins and straps
  input wire logic wp_b_i,
  input wire logic hold_b_i,
  input wire logic dev_addr_bit_low_i,
  input wire logic dev_addr_bit_high_i,
  // potentiometer side
  output wiper_t wiper0_o,
  output wiper_t wiper1_o,
  output logic [`TAP_N-1:0] tap0_o,
  output logic [`TAP_N-1:0] tap1_o,
  output logic nv_busy_o
);

  // ==========================================
  // helpers
  // one-hot tap select from a wiper value
  function automatic logic [`TAP_N-1:0] tap_onehot(input wiper_t w);
    tap_onehot = `TAP_RESET << w;
  endfunction : tap_onehot

  // ==========================================
  // declarations
  pins_t pin_raw; // raw pin group
  pins_t sync1_reg; // first stage
  pins_t sync2_reg; // second stage
  pins_t sync3_reg; // third stage
  pins_t filt_reg; // accepted levels
  pins_t prev_reg; // accepted levels, one cycle old
  logic sel; // selected
  logic live; // selected and not paused
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic wp_fall;
  logic [1:0] strap; // device address straps
  logic paused_reg; // transfer paused
  phase_t phase_reg; // sequence phase
  logic [2:0] bit_reg; // bit within byte
  logic [7:0] shift_reg; // incoming byte
  logic [7:0] rx_byte; // byte including current bit
  logic byte_done;
  logic instr_done;
  logic data_done;
  instr_t instr_reg; // held instruction
  instr_t instr_rx; // instruction being received
  logic rd_act_reg; // read answer in progress
  logic [7:0] out_reg; // outgoing byte
  logic so_reg;
  logic oe_reg;
  logic pend_reg; // complete write awaiting select rise
  logic abort_reg; // protect fell during this frame
  wiper_t data_reg; // write value
  logic commit;
  logic wiper_wr;
  logic nv_start;
  logic busy_reg; // nonvolatile write running
  logic [31:0] nv_cnt_reg;
  logic nv_done;
  wiper_t nv_data_reg;
  logic nv_pot_reg;
  logic [1:0] nv_slot_reg;
  logic recall_reg; // power-up recall pending
  wiper_t wiper_reg [`POT_N]; // wiper positions
  wiper_t slot_mem [`POT_N][`SLOT_N]; // setting slots
  logic [`TAP_N-1:0] tap_reg [`POT_N]; // tap switches

  // ==========================================
  // pin synchronisers
  assign pin_raw = {dev_addr_bit_high_i, dev_addr_bit_low_i, hold_b_i, wp_b_i, si_i, cs_b_i, sck_i};

  // three stages; a level is taken once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync1_reg <= `PINS_IDLE;
      sync2_reg <= `PINS_IDLE;
      sync3_reg <= `PINS_IDLE;
      filt_reg <= `PINS_IDLE;
      prev_reg <= `PINS_IDLE;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
      prev_reg <= filt_reg;
    end
  end

  // edges of the accepted levels
  assign sel = !filt_reg.cs_b;
  assign live = sel && !paused_reg;
  assign sck_rise = live && filt_reg.sck && !prev_reg.sck;
  assign sck_fall = live && !filt_reg.sck && prev_reg.sck;
  assign cs_fall = !filt_reg.cs_b && prev_reg.cs_b;
  assign cs_rise = filt_reg.cs_b && !prev_reg.cs_b;
  assign wp_fall = !filt_reg.wp_b && prev_reg.wp_b;
  assign strap = {filt_reg.addr_hi, filt_reg.addr_lo};

  // ==========================================
  // pause control
  // pause and resume are only taken while the clock is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      paused_reg <= 1'b0;
    end else if (!sel) begin
      paused_reg <= 1'b0;
    end else if (!paused_reg && !filt_reg.hold_b && !filt_reg.sck) begin
      paused_reg <= 1'b1;
    end else if (paused_reg && filt_reg.hold_b && !filt_reg.sck) begin
      paused_reg <= 1'b0;
    end
  end

  // ==========================================
  // receive shifter
  assign rx_byte = {shift_reg[6:0], filt_reg.si};
  assign instr_rx = instr_t'(rx_byte);
  assign byte_done = sck_rise && (bit_reg == `BIT_LAST);
  assign instr_done = byte_done && (phase_reg == ST_INSTR);
  assign data_done = byte_done && (phase_reg == ST_DATA);

  // phase walk; state is kept through a pause
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      phase_reg <= ST_IDLE;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (!sel) begin
      phase_reg <= ST_IDLE;
    end else if (cs_fall) begin
      phase_reg <= ST_INSTR;
      bit_reg <= 3'h0;
    end else if (sck_rise) begin
      shift_reg <= rx_byte;
      bit_reg <= bit_reg + 3'h1;
      case (phase_reg)
        ST_INSTR: if (bit_reg == `BIT_LAST) phase_reg <= ST_DATA;
        ST_DATA: if (bit_reg == `BIT_LAST) phase_reg <= ST_DONE;
        default: ;
      endcase
    end
  end

  // instruction byte hold
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      instr_reg <= '0;
    end else if (instr_done) begin
      instr_reg <= instr_rx;
    end
  end

  // ==========================================
  // read answer
  // load on the instruction's last rise, shift on falls
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rd_act_reg <= 1'b0;
      out_reg <= 8'h00;
      so_reg <= 1'b0;
    end else if (!sel) begin
      rd_act_reg <= 1'b0;
    end else if (instr_done) begin
      rd_act_reg <= !instr_rx.op[0] && (instr_rx.dev == strap);
      if (instr_rx.op[1]) begin
        out_reg <= {`PAD_ZERO, slot_mem[instr_rx.pot][instr_rx.slot]};
      end else begin
        out_reg <= {`PAD_ZERO, wiper_reg[instr_rx.pot]};
      end
    end else if (sck_fall && rd_act_reg && (phase_reg == ST_DATA)) begin
      so_reg <= out_reg[7];
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  // output enable only while selected, unpaused and answering
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= live && rd_act_reg;
    end
  end

  // ==========================================
  // write capture
  assign commit = cs_rise && pend_reg;
  assign wiper_wr = commit && (instr_reg.op == `OP_WR_WIPER);
  assign nv_start = commit && (instr_reg.op == `OP_WR_SLOT) && filt_reg.wp_b && !busy_reg;

  // a full write waits for select to rise
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pend_reg <= 1'b0;
      data_reg <= `SLOT_RESET;
    end else if (cs_rise) begin
      pend_reg <= 1'b0;
    end else if (sel && wp_fall) begin
      pend_reg <= 1'b0;
    end else if (data_done && instr_reg.op[0] && (instr_reg.dev == strap) && !abort_reg) begin
      pend_reg <= 1'b1;
      data_reg <= rx_byte[`WIPER_W-1:0];
    end
  end

  // a protect fall anywhere in the frame kills its write, even before the data ends
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      abort_reg <= 1'b0;
    end else if (!sel) begin
      abort_reg <= 1'b0;
    end else if (wp_fall) begin
      abort_reg <= 1'b1;
    end
  end

  // ==========================================
  // nonvolatile write engine
  assign nv_done = busy_reg && (nv_cnt_reg == 32'(NV_WRITE_CYC - 1));

  // runs to the end regardless of select or protect
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
      nv_cnt_reg <= 32'h0000_0000;
      nv_data_reg <= `SLOT_RESET;
      nv_pot_reg <= 1'b0;
      nv_slot_reg <= 2'h0;
    end else if (nv_start) begin
      busy_reg <= 1'b1;
      nv_cnt_reg <= 32'h0000_0000;
      nv_data_reg <= data_reg;
      nv_pot_reg <= instr_reg.pot;
      nv_slot_reg <= instr_reg.slot;
    end else if (nv_done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      nv_cnt_reg <= nv_cnt_reg + 32'h0000_0001;
    end
  end

  // setting slots, written when the cycle ends
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < `POT_N; p++) begin
        for (int s = 0; s < `SLOT_N; s++) begin
          slot_mem[p][s] <= `SLOT_RESET;
        end
      end
    end else if (nv_done) begin
      slot_mem[nv_pot_reg][nv_slot_reg] <= nv_data_reg;
    end
  end

  // ==========================================
  // wiper registers and taps
  // recall slot 0 once after power-up, then take writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      recall_reg <= 1'b1;
      for (int p = 0; p < `POT_N; p++) begin
        wiper_reg[p] <= `SLOT_RESET;
      end
    end else if (recall_reg) begin
      recall_reg <= 1'b0;
      for (int p = 0; p < `POT_N; p++) begin
        wiper_reg[p] <= slot_mem[p][0];
      end
    end else if (wiper_wr) begin
      wiper_reg[instr_reg.pot] <= data_reg;
    end
  end

  // one tap switch per pot, decoded from its wiper
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < `POT_N; p++) begin
        tap_reg[p] <= `TAP_RESET;
      end
    end else begin
      for (int p = 0; p < `POT_N; p++) begin
        tap_reg[p] <= tap_onehot(wiper_reg[p]);
      end
    end
  end

  // ==========================================
  // outputs
  assign so_o = so_reg;
  assign so_oe_o = oe_reg;
  assign wiper0_o = wiper_reg[0];
  assign wiper1_o = wiper_reg[1];
  assign tap0_o = tap_reg[0];
  assign tap1_o = tap_reg[1];
  assign nv_busy_o = busy_reg;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_commit;
    cs_rise && pend_reg;
  endsequence
  sequence s_launch;
    (instr_reg.op == `OP_WR_SLOT) && filt_reg.wp_b && !busy_reg;
  endsequence

  property p_so_float;
    !sel |=> !so_oe_o;
  endproperty
  a_so_float: assert property (p_so_float) else $error("output driven while deselected");
  property p_hold_float;
    paused_reg |=> !so_oe_o;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("output driven while paused");
  property p_so_fall;
    !$stable(so_o) |-> $past(sck_fall);
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("output changed off a clock fall");
  property p_instr;
    instr_done |=> (phase_reg == ST_DATA) && (instr_reg == $past(rx_byte));
  endproperty
  a_instr: assert property (p_instr) else $error("instruction byte not held");
  property p_launch;
    s_commit ##0 s_launch |=> busy_reg ##1 busy_reg;
  endproperty
  a_launch: assert property (p_launch) else $error("write not launched on select rise");
  property p_wp_block;
    $rose(busy_reg) |-> $past(filt_reg.wp_b) && $past(cs_rise);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("slot write launched while protected");
  property p_abort;
    sel && wp_fall |=> !pend_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("pending write survived protect fall");
  property p_busy_keep;
    busy_reg && !nv_done |=> busy_reg && (nv_data_reg == $past(nv_data_reg));
  endproperty
  a_busy_keep: assert property (p_busy_keep) else $error("running write disturbed");
  property p_recall;
    recall_reg |=> (wiper_reg[0] == $past(slot_mem[0][0])) && (wiper_reg[1] == $past(slot_mem[1][0]));
  endproperty
  a_recall: assert property (p_recall) else $error("power-up recall missed");
  property p_tap;
    1'b1 |=> $onehot(tap_reg[0]) && tap_reg[0][$past(wiper_reg[0])] && $onehot(tap_reg[1]) &&
             tap_reg[1][$past(wiper_reg[1])];
  endproperty
  a_tap: assert property (p_tap) else $error("tap select not one-hot of wiper");
  property p_addr;
    pend_reg |-> (instr_reg.dev == strap);
  endproperty
  a_addr: assert property (p_addr) else $error("write pending for another address");

endmodule : dual_pot_serial_control
`default_nettype wire

// *** verilog/dual_pot_map.svh ***
// constant map for the dual potentiometer serial control
`ifndef DUAL_POT_MAP_SVH
`define DUAL_POT_MAP_SVH
// ==========================================
// widths and counts
`define WIPER_W 6
`define TAP_N 64
`define SLOT_N 4
`define POT_N 2
`define BIT_LAST 3'h7
// ==========================================
// instruction opcodes (op field)
`define OP_RD_WIPER 2'h0
`define OP_WR_WIPER 2'h1
`define OP_RD_SLOT 2'h2
`define OP_WR_SLOT 2'h3
// ==========================================
// reset values and byte padding
`define SLOT_RESET 6'h00
`define TAP_RESET 64'h0000_0000_0000_0001
`define PINS_IDLE 7'h1A
`define PAD_ZERO 2'h0
// ==========================================
// timing
`define CLK_PERIOD_NS 40
`define NV_WRITE_TIME_NS 5000000
`endif

// *** verilog/dual_pot_pkg.sv ***
// types for the dual potentiometer serial control
`default_nettype none
`include "dual_pot_map.svh"
package dual_pot_pkg;
  // wiper position value
  typedef logic [`WIPER_W-1:0] wiper_t;
  // pins sampled from outside the clock domain
  typedef struct packed {
    logic addr_hi;
    logic addr_lo;
    logic hold_b;
    logic wp_b;
    logic si;
    logic cs_b;
    logic sck;
  } pins_t;
  // first byte of a sequence
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] dev;
    logic [1:0] slot;
    logic pot;
    logic rsv;
  } instr_t;
  // sequence phase
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} phase_t;
endpackage : dual_pot_pkg
`default_nettype wire

// *** tb/spi_master_model.sv ***
// serial bus master model that drives the select, clock, data, pause and protect pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  // system clock used to pace the pins
  input wire logic clk_i,
  // answer from the device
  input wire logic so_i,
  input wire logic so_oe_i,
  // pins driven by the master
  output logic sck_o,
  output logic cs_b_o,
  output logic si_o,
  output logic hold_b_o,
  output logic wp_b_o
);
  logic cpol; // idle clock level, 0 for mode (0,0), 1 for mode (1,1)
  int oe_in_pause; // cycles the device drove its output while paused
  // ==========================================
  // pin levels at time zero
  initial begin
    cpol = 1'b0;
    oe_in_pause = 0;
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
    hold_b_o = 1'b1;
    wp_b_o = 1'b1;
  end
  // wait a number of clock cycles
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  // drive the protect pin at the next edge
  task automatic set_wp(input logic v);
    @(posedge clk_i);
    wp_b_o <= v;
  endtask : set_wp
  // ==========================================
  // one whole frame: 16 bits out, last 8 bits sampled back
  task automatic frame(input logic [15:0] tx, input int pause_at, input int wp_at, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i);
    sck_o <= cpol; // clock idles at its mode level
    cs_b_o <= 1'b0; // select falls before any bit
    idle(6);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      sck_o <= 1'b0;
      si_o <= tx[15-k]; // most significant bit first
      if (k == wp_at) begin
        wp_b_o <= 1'b0; // protect drops while selected
      end
      if (k == pause_at) begin
        @(posedge clk_i);
        hold_b_o <= 1'b0; // pause only with clock low
        for (int p = 0; p < 24; p++) begin
          @(posedge clk_i);
          si_o <= ~si_o; // garbage the device must ignore
          if (p > 8 && so_oe_i === 1'b1) begin
            oe_in_pause++;
          end
        end
        @(posedge clk_i);
        si_o <= tx[15-k];
        hold_b_o <= 1'b1; // resume with clock low
      end
      idle(3);
      @(posedge clk_i);
      sck_o <= 1'b1; // device samples on this rise
      idle(3);
      @(negedge clk_i);
      if (k > 7) begin
        rx[15-k] = (so_oe_i === 1'b1) ? so_i : 1'b1; // released data line is pulled high
      end
    end
    @(posedge clk_i);
    sck_o <= cpol;
    si_o <= ~si_o; // released data line shows no stale value
    idle(3);
    @(posedge clk_i);
    cs_b_o <= 1'b1; // select rise launches a pending write
    idle(8);
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

// *** tb/tb_dual_pot_serial_control.sv ***
// self-checking testbench for the dual potentiometer serial control
`timescale 1ns/1ps
`default_nettype none
`include "dual_pot_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_dual_pot_serial_control;
  import dual_pot_pkg::*;
  localparam int NVC = 20; // shortened slot write time
  // ==========================================
  // signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic a_hi = 1'b1; // strap pins, device address 2
  logic a_lo = 1'b0;
  wire logic sck, cs_b, si, hold_b, wp_b, so, so_oe, nv_busy;
  wiper_t wiper0, wiper1;
  logic [`TAP_N-1:0] tap0, tap1;
  logic [7:0] rx; // byte read back
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  // ==========================================
  // design and master model
  dual_pot_serial_control #(.NV_WRITE_CYC(NVC)) dut (
    .clk_sys_i(clk), .rst_b_i(rst_b), .sck_i(sck), .cs_b_i(cs_b), .si_i(si), .so_o(so),
    .so_oe_o(so_oe), .wp_b_i(wp_b), .hold_b_i(hold_b), .dev_addr_bit_low_i(a_lo),
    .dev_addr_bit_high_i(a_hi), .wiper0_o(wiper0), .wiper1_o(wiper1), .tap0_o(tap0),
    .tap1_o(tap1), .nv_busy_o(nv_busy)
  );
  spi_master_model bus (
    .clk_i(clk), .so_i(so), .so_oe_i(so_oe), .sck_o(sck), .cs_b_o(cs_b), .si_o(si),
    .hold_b_o(hold_b), .wp_b_o(wp_b)
  );
  // ==========================================
  // verdict and end of run
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
  // instruction byte: op, device, slot, pot, unused
  function automatic logic [7:0] ins(input logic [1:0] op, input logic [1:0] dev, input logic [1:0] slot,
                                     input logic pot);
    return {op, dev, slot, pot, 1'b0};
  endfunction : ins
  // full frame with a 6-bit value in the data byte
  task automatic xfer(input logic [1:0] op, input logic [1:0] dev, input logic [1:0] slot, input logic pot,
                      input wiper_t val, input int pause_at, input int wp_at);
    bus.frame({ins(op, dev, slot, pot), `PAD_ZERO, val}, pause_at, wp_at, rx);
  endtask : xfer
  // read and compare the returned byte
  task automatic rd(input logic [1:0] op, input logic [1:0] dev, input logic [1:0] slot, input logic pot,
                    input logic [7:0] exp, input int pause_at);
    xfer(op, dev, slot, pot, 6'h00, pause_at, -1);
    `CHK(rx, exp)
  endtask : rd
  // wipers, one-hot taps and a floating output after the frame
  task automatic chk_wiper(input wiper_t e0, input wiper_t e1);
    @(negedge clk);
    `CHK(wiper0, e0)
    `CHK(wiper1, e1)
    `CHK(tap0, 64'h1 << e0)
    `CHK(tap1, 64'h1 << e1)
    `CHK(so_oe, 1'b0)
  endtask : chk_wiper
  // slot write running or not, optional protect drop, then bounded wait for its end
  task automatic chk_busy(input logic exp, input logic drop_wp);
    int n;
    @(negedge clk);
    `CHK(nv_busy, exp)
    if (drop_wp) begin
      bus.set_wp(1'b0);
    end
    n = 0;
    while (nv_busy !== 1'b0 && n < NVC + 10) begin
      @(negedge clk);
      n++;
    end
    `CHK(nv_busy, 1'b0)
  endtask : chk_busy
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk_wiper(6'h00, 6'h00);
    xfer(`OP_WR_WIPER, 2'h2, 2'h0, 1'b0, 6'h2A, -1, -1);
    xfer(`OP_WR_WIPER, 2'h2, 2'h0, 1'b1, 6'h15, 4, -1);
    chk_wiper(6'h2A, 6'h15);
    rd(`OP_RD_WIPER, 2'h2, 2'h0, 1'b0, 8'h2A, -1);
    rd(`OP_RD_WIPER, 2'h2, 2'h0, 1'b1, 8'h15, 11);
    `CHK(bus.oe_in_pause, 0)
    xfer(`OP_WR_WIPER, 2'h1, 2'h0, 1'b0, 6'h3F, -1, -1);
    chk_wiper(6'h2A, 6'h15);
    rd(`OP_RD_WIPER, 2'h1, 2'h0, 1'b0, 8'hFF, -1);
    bus.cpol = 1'b1;
    xfer(`OP_WR_WIPER, 2'h2, 2'h0, 1'b1, 6'h3F, -1, -1);
    rd(`OP_RD_WIPER, 2'h2, 2'h0, 1'b1, 8'h3F, -1);
    bus.cpol = 1'b0;
    chk_wiper(6'h2A, 6'h3F);
    xfer(`OP_WR_SLOT, 2'h2, 2'h1, 1'b0, 6'h33, -1, -1);
    chk_busy(1'b1, 1'b1);
    rd(`OP_RD_SLOT, 2'h2, 2'h1, 1'b0, 8'h33, -1);
    xfer(`OP_WR_SLOT, 2'h2, 2'h2, 1'b1, 6'h11, -1, -1);
    chk_busy(1'b0, 1'b0);
    rd(`OP_RD_SLOT, 2'h2, 2'h2, 1'b1, 8'h00, -1);
    xfer(`OP_WR_WIPER, 2'h2, 2'h0, 1'b0, 6'h07, -1, -1);
    chk_wiper(6'h07, 6'h3F);
    bus.set_wp(1'b1);
    xfer(`OP_WR_WIPER, 2'h2, 2'h0, 1'b0, 6'h10, -1, 12);
    chk_wiper(6'h07, 6'h3F);
    bus.set_wp(1'b1);
    @(posedge clk);
    a_hi <= 1'b0;
    a_lo <= 1'b1;
    repeat (6) @(posedge clk);
    xfer(`OP_WR_WIPER, 2'h1, 2'h0, 1'b1, 6'h01, -1, -1);
    xfer(`OP_WR_WIPER, 2'h2, 2'h0, 1'b0, 6'h3F, -1, -1);
    chk_wiper(6'h07, 6'h01);
    close_out();
  end
endmodule : tb_dual_pot_serial_control
`default_nettype wire
